/* hdl/sis_pkg.sv */
package sis_pkg;

	localparam logic [31:0] ADDR_STATUS = 32'hbc040110;
	localparam logic [31:0] ADDR_MASK = 32'hbc040120;
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

	// Bit positions inside the status word
	localparam int FLAG_LSB = 16;
	localparam int FLAG_MSB = 31;
	localparam int LIVE_MSB = 15;
	localparam int BIT_STX_PAGE = 31;
	localparam int BIT_SRX_HALF = 29;
	localparam int BIT_SRX_PAGE = 28;
	localparam int BIT_DTX_PAGE = 27;
	localparam int BIT_DRX_HALF = 25;
	localparam int BIT_DRX_PAGE = 24;
	localparam int BIT_VIDEO = 3;
	localparam int BIT_VIDEO_N = 2;
	localparam int BIT_BUS_RESET = 13;
	localparam int BIT_SLOT0 = 12;
	localparam int BIT_FACTORY = 10;
	localparam int BIT_DENS_HI = 7;
	localparam int BIT_SLOT1 = 5;
	localparam int BIT_DENS_LO = 4;
	localparam int BIT_TX_EMPTY = 1;
	localparam int BIT_RX_FULL = 0;

	// DMA events, one-cycle pulses, listed from bit 31 down to bit 16
	typedef struct packed {
		logic stxPageEnd;
		logic stxMemErr;
		logic srxHalfPage;
		logic srxPageEnd;
		logic dtxPageEnd;
		logic dtxMemErr;
		logic drxHalfPage;
		logic drxPageEnd;
		logic floppyErr;
		logic isdnTxLoad;
		logic isdnRxLoad;
		logic isdnErr;
		logic scsiLoad;
		logic scsiOverrun;
		logic scsiMemErr;
		logic etherMemErr;
	} sis_evt_t;

	// Live device status lines
	typedef struct packed {
		logic floppyIrq;
		logic nvramDefaultJumper;
		logic desktopBusReset;
		logic slot0Irq;
		logic isdnIrq;
		logic factoryModeJumper;
		logic scsiIrq;
		logic etherIrq;
		logic floppyDensityHi;
		logic serialIrq;
		logic slot1Irq;
		logic floppyDensityLo;
		logic videoIrq;
		logic desktopTxEmpty;
		logic desktopRxFull;
	} sis_live_t;

	// Channel halt levels, high while the channel is disabled
	typedef struct packed {
		logic serialTx;
		logic serialRx;
		logic desktopTx;
		logic desktopRx;
		logic floppy;
		logic isdn;
		logic scsi;
		logic ether;
	} sis_halt_t;

endpackage

/* hdl/sis_top.sv */
// What this block does
// - Upper half holds sticky DMA event flags
// - Writing zero clears flag; one keeps it
// - Reset forces all DMA flags to zero
// - Lower half reads live device lines
// - Transmit page end flags and halts channel
// - DMA memory errors flag and halt channel
// - Serial receive half page sets flag only
// - Desktop receive half page sets flag only
// - Serial receive page end halts, sets both
// - Desktop receive page end halts, sets both
// - ISDN buffer pointer loads set flags
// - ISDN error flag halts both directions
// - SCSI buffer pointer load sets flag
// - SCSI overrun flags and halts DMA
// - SCSI memory read error halts DMA
// - Ethernet memory error flags and halts
// - Bits seven and four show density
// - Bit thirteen shows desktop bus reset
// - Bit ten shows factory mode jumper
// - Bits twelve and five show slot interrupts
// - Bit two is inverse of bit three
// - Bits one and zero show desktop port
// - Mask gates processor interrupt, resets zero
//
// Decided for this implementation: register access over Wishbone.
module sis_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [31:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	input wire sis_pkg::sis_evt_t dmaEvt,
	input wire sis_pkg::sis_live_t liveIn,
	output sis_pkg::sis_halt_t chanHalt,
	output logic cpuIrq
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic wbAck_ff;
	logic [31:0] wbDatR_ff;
	logic [15:0] flags_ff;
	logic [31:0] mask_ff;
	logic cpuIrq_ff;
	sis_pkg::sis_halt_t chanHalt_ff;
	sis_pkg::sis_live_t liveMeta_ff;
	sis_pkg::sis_live_t liveSync_ff;
	logic hitStatusQ;

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire logic busReq = wbCyc & wbStb;
	wire logic firstCycle = busReq & ~wbAck_ff;
	wire logic commit = busReq & wbAck_ff;
	wire logic hitStatus = wbAdr == sis_pkg::ADDR_STATUS;
	wire logic hitMask = wbAdr == sis_pkg::ADDR_MASK;
	wire logic wrStatus = commit & wbWe & hitStatus;
	wire logic wrMask = commit & wbWe & hitMask;

	wire logic [31:0] byteMask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};

	////////////////////////////////////////////////////////////////////////
	// Status word

	wire logic [15:0] evtVec = dmaEvt;

	// Page end on a receive channel also raises its half page flag
	wire logic [15:0] evtAll = evtVec
		| (16'h0001 << (sis_pkg::BIT_SRX_HALF - sis_pkg::FLAG_LSB)) & {16{dmaEvt.srxPageEnd}}
		| (16'h0001 << (sis_pkg::BIT_DRX_HALF - sis_pkg::FLAG_LSB)) & {16{dmaEvt.drxPageEnd}};

	// Written zeros in enabled upper lanes clear; ones do nothing
	wire logic [31:0] clrWord = ~wbDatW & byteMask;
	wire logic [15:0] clrVec = wrStatus ? clrWord[sis_pkg::FLAG_MSB:sis_pkg::FLAG_LSB] : 16'h0000;

	// Hardware set wins over a clear in the same cycle
	wire logic [15:0] nxt_flags = (flags_ff & ~clrVec) | evtAll;

	// Named views of the flag bits
	wire sis_pkg::sis_evt_t flagNow = flags_ff;
	wire sis_pkg::sis_evt_t flagNxt = nxt_flags;

	wire logic [15:0] liveWord = {
		liveSync_ff.floppyIrq,
		liveSync_ff.nvramDefaultJumper,
		liveSync_ff.desktopBusReset,
		liveSync_ff.slot0Irq,
		liveSync_ff.isdnIrq,
		liveSync_ff.factoryModeJumper,
		liveSync_ff.scsiIrq,
		liveSync_ff.etherIrq,
		liveSync_ff.floppyDensityHi,
		liveSync_ff.serialIrq,
		liveSync_ff.slot1Irq,
		liveSync_ff.floppyDensityLo,
		liveSync_ff.videoIrq,
		~liveSync_ff.videoIrq,
		liveSync_ff.desktopTxEmpty,
		liveSync_ff.desktopRxFull
	};

	wire logic [31:0] statusWord = {flags_ff, liveWord};

	////////////////////////////////////////////////////////////////////////
	// Mask and interrupt

	wire logic [31:0] nxt_mask = wrMask ? (mask_ff & ~byteMask) | (wbDatW & byteMask) : mask_ff;
	wire logic nxt_cpuIrq = |(statusWord & mask_ff);

	////////////////////////////////////////////////////////////////////////
	// Channel halts

	sis_pkg::sis_halt_t nxt_halt;
	assign nxt_halt.serialTx = dmaEvt.stxPageEnd | flagNxt.stxPageEnd | flagNxt.stxMemErr;
	assign nxt_halt.serialRx = flagNxt.srxPageEnd;
	assign nxt_halt.desktopTx = flagNxt.dtxPageEnd | flagNxt.dtxMemErr;
	assign nxt_halt.desktopRx = flagNxt.drxPageEnd;
	assign nxt_halt.floppy = flagNxt.floppyErr;
	assign nxt_halt.isdn = flagNxt.isdnErr;
	assign nxt_halt.scsi = flagNxt.scsiOverrun | flagNxt.scsiMemErr;
	assign nxt_halt.ether = flagNxt.etherMemErr;

	////////////////////////////////////////////////////////////////////////
	// Read data

	wire logic [31:0] nxt_rdData = hitStatus ? statusWord
		: hitMask ? mask_ff
		: sis_pkg::READ_UNMAPPED;

	////////////////////////////////////////////////////////////////////////
	// Flip-flops

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			liveMeta_ff <= '0;
			liveSync_ff <= '0;
		end else begin
			liveMeta_ff <= liveIn;
			liveSync_ff <= liveMeta_ff;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wbAck_ff <= 1'b0;
		end else begin
			wbAck_ff <= firstCycle;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wbDatR_ff <= sis_pkg::READ_UNMAPPED;
		end else begin
			wbDatR_ff <= firstCycle ? nxt_rdData : wbDatR_ff;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= sis_pkg::FLAGS_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_ff <= sis_pkg::MASK_RESET;
		end else begin
			mask_ff <= nxt_mask;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpuIrq_ff <= 1'b0;
		end else begin
			cpuIrq_ff <= nxt_cpuIrq;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chanHalt_ff <= '0;
		end else begin
			chanHalt_ff <= nxt_halt;
		end
	end

	assign wbAck = wbAck_ff;
	assign wbDatR = wbDatR_ff;
	assign chanHalt = chanHalt_ff;
	assign cpuIrq = cpuIrq_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_statusWrite;
		wrStatus && evtAll == 16'h0000;
	endsequence

	sequence s_readTaken;
		firstCycle && !wbWe && hitStatus;
	endsequence

	sequence s_readMask;
		firstCycle && !wbWe && hitMask;
	endsequence

	a_set_is_sticky: assert property (
		evtAll != 16'h0000 |=> (flags_ff & $past(evtAll)) == $past(evtAll))
		else $error("event did not set its flag");

	a_write_zero_clears: assert property (
		s_statusWrite |=> flags_ff == ($past(flags_ff) & ~$past(clrVec)))
		else $error("write did not clear exactly the zero bits");

	a_flags_hold: assert property (
		!wrStatus && evtAll == 16'h0000 |=> flags_ff == $past(flags_ff))
		else $error("flags changed without cause");

	a_reset_clear: assert property (@(posedge mclk) disable iff (1'b0)
		!$past(rst_n) |-> flags_ff == sis_pkg::FLAGS_RESET)
		else $error("flags not clear after reset");

	a_live_read: assert property (
		s_readTaken |=> wbAck && wbDatR[sis_pkg::LIVE_MSB:0] == $past(liveWord))
		else $error("live bits not read back");

	a_video_inverse: assert property (
		wbAck |-> !hitStatusQ || wbDatR[sis_pkg::BIT_VIDEO_N] != wbDatR[sis_pkg::BIT_VIDEO])
		else $error("video bits not inverse");

	a_tx_page_halt: assert property (
		dmaEvt.stxPageEnd |=> chanHalt.serialTx && flags_ff[sis_pkg::BIT_STX_PAGE - sis_pkg::FLAG_LSB])
		else $error("serial transmit page end did not halt");

	a_rx_page_pair: assert property (
		dmaEvt.srxPageEnd |=> chanHalt.serialRx
			&& flags_ff[sis_pkg::BIT_SRX_PAGE - sis_pkg::FLAG_LSB]
			&& flags_ff[sis_pkg::BIT_SRX_HALF - sis_pkg::FLAG_LSB])
		else $error("serial receive page end incomplete");

	a_half_no_halt: assert property (
		dmaEvt.srxHalfPage && !dmaEvt.srxPageEnd && !flagNow.srxPageEnd |=> !chanHalt.serialRx)
		else $error("half page halted receive");

	a_desk_pair: assert property (
		dmaEvt.drxPageEnd |=> chanHalt.desktopRx
			&& flags_ff[sis_pkg::BIT_DRX_HALF - sis_pkg::FLAG_LSB])
		else $error("desktop receive page end incomplete");

	a_irq_gate: assert property (
		##1 cpuIrq == |($past(statusWord) & $past(mask_ff)))
		else $error("interrupt not gated by mask");

	a_low_write_none: assert property (
		wrStatus |=> liveMeta_ff == $past(liveIn))
		else $error("write disturbed live path");

	a_ack_one: assert property (
		busReq && !wbAck |=> wbAck ##1 !wbAck)
		else $error("ack not one cycle");

	a_stx_err_halt: assert property (
		dmaEvt.stxMemErr |=> chanHalt.serialTx && flagNow.stxMemErr)
		else $error("serial transmit error did not halt");

	a_dtx_page_halt: assert property (
		dmaEvt.dtxPageEnd |=> chanHalt.desktopTx && flagNow.dtxPageEnd)
		else $error("desktop transmit page end did not halt");

	a_dtx_err_halt: assert property (
		dmaEvt.dtxMemErr |=> chanHalt.desktopTx && flagNow.dtxMemErr)
		else $error("desktop transmit error did not halt");

	a_floppy_err_halt: assert property (
		dmaEvt.floppyErr |=> chanHalt.floppy && flagNow.floppyErr)
		else $error("floppy error did not halt");

	a_dtx_halt_level: assert property (
		chanHalt.desktopTx == (flagNow.dtxPageEnd || flagNow.dtxMemErr))
		else $error("desktop transmit halt not tied to flags");

	a_drx_half_set: assert property (
		dmaEvt.drxHalfPage |=> flagNow.drxHalfPage)
		else $error("desktop half page flag not set");

	a_drx_half_free: assert property (
		dmaEvt.drxHalfPage && !dmaEvt.drxPageEnd && !flagNow.drxPageEnd |=> !chanHalt.desktopRx)
		else $error("desktop half page halted receive");

	a_rx_halt_level: assert property (
		chanHalt.serialRx == flagNow.srxPageEnd && chanHalt.desktopRx == flagNow.drxPageEnd)
		else $error("receive halt not tied to page flag");

	a_isdn_load_set: assert property (
		(dmaEvt.isdnTxLoad |=> flagNow.isdnTxLoad) and (dmaEvt.isdnRxLoad |=> flagNow.isdnRxLoad))
		else $error("isdn load flag not set");

	a_isdn_err_halt: assert property (
		dmaEvt.isdnErr |=> chanHalt.isdn && flagNow.isdnErr)
		else $error("isdn error did not halt");

	a_scsi_load_set: assert property (
		dmaEvt.scsiLoad |=> flagNow.scsiLoad)
		else $error("scsi load flag not set");

	a_scsi_overrun_halt: assert property (
		dmaEvt.scsiOverrun |=> chanHalt.scsi && flagNow.scsiOverrun)
		else $error("scsi overrun did not halt");

	a_scsi_read_halt: assert property (
		dmaEvt.scsiMemErr |=> chanHalt.scsi && flagNow.scsiMemErr)
		else $error("scsi read error did not halt");

	a_scsi_halt_level: assert property (
		chanHalt.scsi == (flagNow.scsiOverrun || flagNow.scsiMemErr))
		else $error("scsi halt not tied to flags");

	a_ether_halt: assert property (
		dmaEvt.etherMemErr |=> chanHalt.ether && flagNow.etherMemErr)
		else $error("ethernet error did not halt");

	a_other_halt_level: assert property (
		chanHalt.floppy == flagNow.floppyErr && chanHalt.isdn == flagNow.isdnErr
			&& chanHalt.ether == flagNow.etherMemErr)
		else $error("channel halt not tied to flag");

	a_density_read: assert property (
		s_readTaken |=> wbDatR[sis_pkg::BIT_DENS_HI] == $past(liveSync_ff.floppyDensityHi)
			&& wbDatR[sis_pkg::BIT_DENS_LO] == $past(liveSync_ff.floppyDensityLo))
		else $error("density bits misplaced");

	a_jumper_read: assert property (
		s_readTaken |=> wbDatR[sis_pkg::BIT_BUS_RESET] == $past(liveSync_ff.desktopBusReset)
			&& wbDatR[sis_pkg::BIT_FACTORY] == $past(liveSync_ff.factoryModeJumper))
		else $error("reset or jumper bit misplaced");

	a_slot_read: assert property (
		s_readTaken |=> wbDatR[sis_pkg::BIT_SLOT0] == $past(liveSync_ff.slot0Irq)
			&& wbDatR[sis_pkg::BIT_SLOT1] == $past(liveSync_ff.slot1Irq))
		else $error("slot interrupt bits misplaced");

	a_desk_port_read: assert property (
		s_readTaken |=> wbDatR[sis_pkg::BIT_TX_EMPTY] == $past(liveSync_ff.desktopTxEmpty)
			&& wbDatR[sis_pkg::BIT_RX_FULL] == $past(liveSync_ff.desktopRxFull))
		else $error("desktop port bits misplaced");

	a_flags_read: assert property (
		s_readTaken |=> wbDatR[sis_pkg::FLAG_MSB:sis_pkg::FLAG_LSB] == $past(flags_ff))
		else $error("flags not read back");

	a_mask_read: assert property (
		s_readMask |=> wbDatR == $past(mask_ff))
		else $error("mask not read back");

	a_unmapped_zero: assert property (
		firstCycle && !wbWe && !hitStatus && !hitMask |=> wbDatR == sis_pkg::READ_UNMAPPED)
		else $error("unmapped read not zero");

	a_irq_needs_mask: assert property (
		cpuIrq |-> |$past(mask_ff))
		else $error("interrupt raised with mask clear");

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hitStatusQ <= 1'b0;
		end else begin
			hitStatusQ <= firstCycle & hitStatus & ~wbWe;
		end
	end

endmodule

/* tb/sis_far_end.sv */
module sis_far_end (
	input wire logic mclk,
	output sis_pkg::sis_evt_t dmaEvt,
	output sis_pkg::sis_live_t liveIn
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		dmaEvt = '0;
		liveIn = '0;
	end
	// One-cycle event pulse
	task pulse(input logic [15:0] e);
		@(posedge mclk);
		dmaEvt <= e;
		@(posedge mclk);
		dmaEvt <= '0;
	endtask
	task setLive(input logic [14:0] l);
		@(posedge mclk);
		liveIn <= l;
	endtask
endmodule

/* tb/system_interrupt_status_bench.sv */
module system_interrupt_status_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ST = sis_pkg::ADDR_STATUS;
	localparam logic [31:0] MK = sis_pkg::ADDR_MASK;
	logic mclk = 0, rst_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, cpuIrq;
	logic [31:0] wbAdr = '0, wbDatW = '0, wbDatR, rd;
	logic [3:0] wbSel = '0;
	sis_pkg::sis_evt_t dmaEvt;
	sis_pkg::sis_live_t liveIn;
	sis_pkg::sis_halt_t chanHalt;
	int fail_count = 0, total_checks = 0;
	always #25 mclk = ~mclk;
	sis_top dut_u (.mclk(mclk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
		.dmaEvt(dmaEvt), .liveIn(liveIn), .chanHalt(chanHalt), .cpuIrq(cpuIrq));
	sis_far_end far_u (.mclk(mclk), .dmaEvt(dmaEvt), .liveIn(liveIn));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wb(input logic we, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r);
		@(posedge mclk);
		wbCyc <= 1;
		wbStb <= 1;
		wbWe <= we;
		wbAdr <= a;
		wbDatW <= d;
		wbSel <= s;
		do begin
			@(posedge mclk);
		end while (wbAck !== 1'b1);
		r = wbDatR;
		wbCyc <= 0;
		wbStb <= 0;
	endtask
	function logic [31:0] liveExp(input logic [14:0] l);
		return {16'h0000, l[14:2], ~l[2], l[1:0]};
	endfunction
	function logic [31:0] haltExp(input logic [15:0] f);
		return {24'h0, f[15] | f[14], f[12], f[11] | f[10], f[8], f[7], f[4], f[2] | f[1], f[0]};
	endfunction
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		wb(0, ST, 0, 4'hf, rd);
		chk(rd, liveExp(15'h0));
		wb(1, 32'hbc040130, 32'hffffffff, 4'hf, rd);
		wb(0, 32'hbc040130, 0, 4'hf, rd);
		chk(rd, sis_pkg::READ_UNMAPPED);
		wb(0, MK, 0, 4'hf, rd);
		chk(rd, sis_pkg::MASK_RESET);
		chk(32'(chanHalt), 0);
		$display("t_reset done");
	endtask
	task t_flags;
		logic [15:0] f;
		for (int i = 0; i < 16; i++) begin
			f = 16'h0001 << i;
			f[13] = f[13] | (i == 12);
			f[9] = f[9] | (i == 8);
			far_u.pulse(16'h0001 << i);
			wb(0, ST, 0, 4'hf, rd);
			chk(rd[31:16], f);
			chk(32'(chanHalt), haltExp(f));
			wb(1, ST, 32'hffffffff, 4'hf, rd);
			wb(0, ST, 0, 4'hf, rd);
			chk(rd[31:16], f);
			wb(1, ST, 0, 4'hf, rd);
			wb(0, ST, 0, 4'hf, rd);
			chk(rd[31:16], 0);
			chk(32'(chanHalt), 0);
		end
		$display("t_flags done");
	endtask
	task t_lanes;
		far_u.pulse(16'h8080);
		wb(1, ST, 0, 4'h8, rd);
		wb(0, ST, 0, 4'hf, rd);
		chk(rd[31:16], 16'h0080);
		wb(1, ST, 0, 4'h4, rd);
		wb(0, ST, 0, 4'hf, rd);
		chk(rd[31:16], 0);
		far_u.pulse(16'h0001);
		fork
			wb(1, ST, 0, 4'hf, rd);
			begin
				@(posedge mclk);
				far_u.pulse(16'h0010);
			end
		join
		wb(0, ST, 0, 4'hf, rd);
		chk(rd[31:16], 16'h0010);
		wb(1, ST, 0, 4'hf, rd);
		$display("t_lanes done");
	endtask
	task t_irq;
		far_u.pulse(16'h0001);
		wb(0, ST, 0, 4'hf, rd);
		chk(rd[31:16], 16'h0001);
		chk(32'(cpuIrq), 0);
		wb(1, MK, 32'h00010000, 4'hf, rd);
		wb(0, MK, 0, 4'hf, rd);
		chk(rd, 32'h00010000);
		chk(32'(cpuIrq), 1);
		wb(1, ST, 0, 4'hf, rd);
		repeat (2) @(posedge mclk);
		#1 chk(32'(cpuIrq), 0);
		$display("t_irq done");
	endtask
	task t_live;
		logic [14:0] l;
		for (int i = 0; i < 16; i++) begin
			l = (i < 15) ? (15'h0001 << i) : 15'h0048;
			far_u.setLive(l);
			repeat (4) @(posedge mclk);
			wb(1, ST, 32'hffff0000 | ~liveExp(l), 4'hf, rd);
			wb(0, ST, 0, 4'hf, rd);
			chk(rd, liveExp(l));
		end
		$display("t_live done");
	endtask
	task t_midreset;
		wb(1, MK, 32'hffffffff, 4'hf, rd);
		far_u.pulse(16'hffff);
		@(posedge mclk);
		rst_n <= 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1;
		repeat (3) @(posedge mclk);
		chk(32'(chanHalt), 0);
		chk(32'(cpuIrq), 0);
		wb(0, ST, 0, 4'hf, rd);
		chk(rd, liveExp(15'h0048));
		wb(0, MK, 0, 4'hf, rd);
		chk(rd, sis_pkg::MASK_RESET);
		$display("t_midreset done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		t_reset;
		t_flags;
		t_lanes;
		t_irq;
		t_live;
		t_midreset;
		tally_and_finish;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		tally_and_finish;
	end
endmodule
